// ==== shared/pmd_ctrl_defs.svh ====
`ifndef PMD_CTRL_DEFS_SVH
`define PMD_CTRL_DEFS_SVH

// Register byte offsets
`define OFS_TX_DISABLE 8'h00
`define OFS_PMD_CONTROL 8'h04
`define OFS_SIGNAL_DETECT 8'h08
`define OFS_FAULT 8'h0C
`define OFS_TRAIN_STATUS 8'h10
`define OFS_TEST_CONTROL 8'h14
`define OFS_RESP_LATE 8'h18

// Field positions
`define BIT_GLOBAL_TX_DIS 0
`define BIT_LANE_TX_DIS_LO 1
`define BIT_RESTART_TRAIN 0
`define BIT_TRAIN_ENABLE 1
`define BIT_GLOBAL_SD 0
`define BIT_LANE_SD_LO 1
`define BIT_FAULT_ANY 0
`define BIT_FAULT_RX 1
`define BIT_FAULT_TX 2
`define BIT_LOOPBACK 0
`define BIT_FAULT_AUTO_DIS 1

// Reset values
`define RST_TX_DISABLE 5'h00
`define RST_TRAIN_ENABLE 1'b1
`define RST_LOOPBACK 1'b0
`define RST_FAULT_AUTO_DIS 1'b0

// Timing
`define CLK_HZ 50000000
`define ALERT_DETECT_NS 500
`define ALERT_DETECT_CYC ((`ALERT_DETECT_NS * (`CLK_HZ / 1000000)) / 1000)
`define RESP_LIMIT_US 2000
`define RESP_LIMIT_CYC (`RESP_LIMIT_US * (`CLK_HZ / 1000000))
`define STARTUP_GRACE_MS 50
`define STARTUP_GRACE_CYC (`STARTUP_GRACE_MS * (`CLK_HZ / 1000))

// Alert pattern half period in bits
`define ALERT_HALF_BITS 8

// AXI responses
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// ==== shared/pmd_ctrl_pkg.sv ====
`default_nettype none
package pmd_ctrl_pkg;

   // Transmit and receive power modes
   typedef enum logic [1:0] {
      MODE_DATA  = 2'b00,
      MODE_QUIET = 2'b01,
      MODE_ALERT = 2'b10
   } pmd_mode_e;

   // Per-lane training status, packed in status register order
   typedef struct packed {
      logic training_failure;
      logic training;
      logic frame_lock;
      logic rx_trained;
   } lane_train_s;

   // Training frame exchange seen by one lane's responder
   typedef struct packed {
      logic rx_marker;
      logic [5:0] rx_coef_update;
      logic tx_marker;
      logic tx_status_done;
   } lane_frame_s;

endpackage
`default_nettype wire

// ==== rtl/quad_lane_pmd_control.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pmd_ctrl_defs.svh"

// Behaviour
// - tx_bit one drives positive line level
// - ALERT sends 8 ones, 8 zeros, preset
// - Outside ALERT use trained equalizer coefficients
// - Positive line level delivered as rx_bit one
// - Global detect is AND of lanes
// - Lane detect follows training signal_detect
// - Training disabled forces all detects high
// - Entering rx QUIET clears lane detects
// - Alert energy sets detect within 500 ns
// - Quiet low-level input keeps detect low
// - Global disable silences all transmitters
// - Fault may set global disable itself
// - Loopback ignores transmit disables
// - tx QUIET turns transmitters off, on
// - Lane disable silences only that lane
// - Fault may set every lane disable
// - Loopback routes transmit data to receiver
// - Fault is OR of fault sources
// - Disable not a fault; tx fault disables
// - Answer requests within 2 ms after grace
// - Measure marker to marker, grace from AN_GOOD_CHECK
// - Changed update field is a new request
// - Lane training status readable in register
// - Global disable and training enable reachable
module quad_lane_pmd_control
   import pmd_ctrl_pkg::*;
#(
   parameter int LANES = 4,
   parameter bit DEEP_SLEEP = 1'b1,
   parameter bit PER_LANE_DISABLE = 1'b1,
   parameter int RESP_LIMIT_CYC = `RESP_LIMIT_CYC,
   parameter int STARTUP_GRACE_CYC = `STARTUP_GRACE_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Service interface
   input wire logic [LANES-1:0] tx_bit,
   output logic [LANES-1:0] rx_bit,
   input wire pmd_mode_e tx_mode,
   input wire pmd_mode_e rx_mode,
   output logic global_signal_detect,
   output logic [LANES-1:0] lane_signal_detect,
   output logic pmd_fault,
   // Line side, sampled and driven as digital levels
   output logic [LANES-1:0] line_out,
   output logic [LANES-1:0] tx_enabled,
   output logic eq_use_preset,
   input wire logic [LANES-1:0] line_in,
   input wire logic [LANES-1:0] alert_energy,
   // Training and fault sources
   input wire logic [LANES-1:0] train_signal_detect,
   input wire lane_train_s [LANES-1:0] train_status,
   input wire lane_frame_s [LANES-1:0] train_frame,
   input wire logic an_good_check_entry,
   input wire logic rx_fault_in,
   input wire logic tx_fault_in,
   output logic restart_training,
   output logic train_enable
);

   localparam int ALERT_FILT_CYC = (`ALERT_DETECT_CYC > 3) ? (`ALERT_DETECT_CYC / 2) : 1;
   localparam int RESP_W = $clog2(RESP_LIMIT_CYC + 1);
   localparam int GRACE_W = $clog2(STARTUP_GRACE_CYC + 1);
   localparam int FILT_W = $clog2(ALERT_FILT_CYC + 1);

   // Register decode shared by read and write channels
   function automatic logic addr_hit(input logic [7:0] a);
      case (a)
         `OFS_TX_DISABLE, `OFS_PMD_CONTROL, `OFS_SIGNAL_DETECT, `OFS_FAULT,
         `OFS_TRAIN_STATUS, `OFS_TEST_CONTROL, `OFS_RESP_LATE: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   endfunction

   logic [4:0] tx_disable;
   logic loopback;
   logic fault_auto_dis;
   logic [LANES-1:0] resp_late;
   logic [LANES-1:0] sd_stat;
   logic global_sd_stat;
   logic rx_fault_q;
   logic tx_fault_q;
   lane_train_s [LANES-1:0] train_q;
   logic [7:0] aw_addr;
   logic aw_got;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_got;
   logic [3:0] alert_cnt;
   logic rx_quiet_q;
   logic grace_run;
   logic [GRACE_W-1:0] grace_cnt;

   // Write channel: address and data latched independently, then applied together
   wire do_write = aw_got && w_got && !s_axi_bvalid;
   wire wr_hit = addr_hit(aw_addr);
   wire wr_b0 = do_write && wr_hit && w_strb[0];
   wire wr_txd = wr_b0 && (aw_addr == `OFS_TX_DISABLE);
   wire wr_ctl = wr_b0 && (aw_addr == `OFS_PMD_CONTROL);
   wire wr_tst = wr_b0 && (aw_addr == `OFS_TEST_CONTROL);
   wire wr_late = wr_b0 && (aw_addr == `OFS_RESP_LATE);

   // Fault aggregation; late training answers are the block's own fault source
   wire any_fault = rx_fault_in || tx_fault_in || (|resp_late);
   wire auto_dis = fault_auto_dis && any_fault;
   // Transmit disable is not itself a fault; a tx fault always sets global disable
   wire [4:0] txd_set = {{4{auto_dis && PER_LANE_DISABLE}}, auto_dis || tx_fault_in};
   wire [4:0] next_tx_disable = (wr_txd ? w_data[4:0] : tx_disable) | txd_set;

   // Transmit, receive-quiet and grace state shared by all lanes
   wire alert_on = DEEP_SLEEP && (tx_mode == MODE_ALERT);
   wire quiet_tx = DEEP_SLEEP && (tx_mode == MODE_QUIET);
   wire alert_bit = (alert_cnt < 4'(`ALERT_HALF_BITS));
   wire rx_quiet = DEEP_SLEEP && (rx_mode == MODE_QUIET);
   wire rx_quiet_entry = rx_quiet && !rx_quiet_q;
   wire grace_done = !grace_run && (grace_cnt == GRACE_W'(STARTUP_GRACE_CYC));

   logic [LANES-1:0] next_sd;
   logic [LANES-1:0] next_line;
   logic [LANES-1:0] next_rx;
   logic [LANES-1:0] lane_off;
   logic [LANES-1:0] late_set;

   genvar i;
   generate
      for (i = 0; i < LANES; i = i + 1) begin : g_lane
         logic [FILT_W-1:0] filt_cnt;
         logic [5:0] prev_coef;
         logic pending;
         logic [RESP_W-1:0] resp_cnt;

         // A lane is silent under global, lane or quiet-mode disable
         assign lane_off[i] = tx_disable[`BIT_GLOBAL_TX_DIS]
            || (PER_LANE_DISABLE && tx_disable[`BIT_LANE_TX_DIS_LO + i])
            || quiet_tx;
         // Silent lanes hold a constant low level; alert overrides requested bits
         assign next_line[i] = lane_off[i] ? 1'b0 : (alert_on ? alert_bit : tx_bit[i]);
         // Loopback taps the requested data, so disables never reach it
         assign next_rx[i] = loopback ? tx_bit[i] : line_in[i];

         // Detect priority: training off, quiet entry, quiet alert watch, training
         wire filt_done = (filt_cnt == FILT_W'(ALERT_FILT_CYC));
         assign next_sd[i] = !train_enable ? 1'b1
            : rx_quiet_entry ? 1'b0
            : rx_quiet ? (lane_signal_detect[i] || filt_done)
            : train_signal_detect[i];

         // Glitch filter on the energy comparator, well inside the 500 ns budget
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               filt_cnt <= '0;
            end else if (!rx_quiet || !alert_energy[i]) begin
               filt_cnt <= '0;
            end else if (!filt_done) begin
               filt_cnt <= filt_cnt + FILT_W'(1);
            end
         end

         // New request when the update field changes between frames
         wire new_req = train_frame[i].rx_marker && (train_frame[i].rx_coef_update != prev_coef);
         wire answered = pending && train_frame[i].tx_marker && train_frame[i].tx_status_done;
         assign late_set[i] = pending && grace_done && (resp_cnt == RESP_W'(RESP_LIMIT_CYC));

         // Response timer runs from request marker to answer marker
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               prev_coef <= '0;
               pending <= 1'b0;
               resp_cnt <= '0;
            end else begin
               if (train_frame[i].rx_marker) begin
                  prev_coef <= train_frame[i].rx_coef_update;
               end
               if (new_req && !pending) begin
                  pending <= 1'b1;
                  resp_cnt <= '0;
               end else if (answered) begin
                  pending <= 1'b0;
               end else if (pending && resp_cnt != RESP_W'(RESP_LIMIT_CYC)) begin
                  resp_cnt <= resp_cnt + RESP_W'(1);
               end
            end
         end
      end
   endgenerate

   // Alert pattern phase, restarted so each alert begins with ones
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         alert_cnt <= 4'h0;
      end else begin
         alert_cnt <= alert_on ? alert_cnt + 4'h1 : 4'h0;
      end
   end

   // Start-up grace timer, armed on each AN_GOOD_CHECK entry
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         grace_run <= 1'b0;
         grace_cnt <= '0;
      end else if (an_good_check_entry) begin
         grace_run <= 1'b1;
         grace_cnt <= '0;
      end else if (grace_run) begin
         grace_cnt <= grace_cnt + GRACE_W'(1);
         if (grace_cnt == GRACE_W'(STARTUP_GRACE_CYC - 1)) begin
            grace_run <= 1'b0;
         end
      end
   end

   // Line and service outputs, all registered
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         line_out <= '0;
         tx_enabled <= '0;
         rx_bit <= '0;
         eq_use_preset <= 1'b0;
         lane_signal_detect <= '0;
         global_signal_detect <= 1'b0;
         pmd_fault <= 1'b0;
         rx_quiet_q <= 1'b0;
      end else begin
         line_out <= next_line;
         tx_enabled <= ~lane_off;
         rx_bit <= next_rx;
         eq_use_preset <= alert_on;
         lane_signal_detect <= next_sd;
         global_signal_detect <= &next_sd;
         pmd_fault <= any_fault;
         rx_quiet_q <= rx_quiet;
      end
   end

   // Snapshot of status for software so each read sees settled bits
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sd_stat <= '0;
         global_sd_stat <= 1'b0;
         rx_fault_q <= 1'b0;
         tx_fault_q <= 1'b0;
         train_q <= '0;
      end else begin
         sd_stat <= lane_signal_detect;
         global_sd_stat <= global_signal_detect;
         rx_fault_q <= rx_fault_in;
         tx_fault_q <= tx_fault_in;
         train_q <= train_status;
      end
   end

   // Control registers; hardware sets win over software writes and clears
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_disable <= `RST_TX_DISABLE;
         train_enable <= `RST_TRAIN_ENABLE;
         restart_training <= 1'b0;
         loopback <= `RST_LOOPBACK;
         fault_auto_dis <= `RST_FAULT_AUTO_DIS;
         resp_late <= '0;
      end else begin
         tx_disable <= next_tx_disable;
         restart_training <= wr_ctl && w_data[`BIT_RESTART_TRAIN];
         if (wr_ctl) begin
            train_enable <= w_data[`BIT_TRAIN_ENABLE];
         end
         if (wr_tst) begin
            loopback <= w_data[`BIT_LOOPBACK];
            fault_auto_dis <= w_data[`BIT_FAULT_AUTO_DIS];
         end
         resp_late <= (resp_late & ~(wr_late ? w_data[LANES-1:0] : '0)) | late_set;
      end
   end

   // Write handshake: ready drops once taken and returns once the response is taken
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_OKAY;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_got <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_got <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read data selection
   wire rd_hit = addr_hit(s_axi_araddr);
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h00000000;
      case (s_axi_araddr)
         `OFS_TX_DISABLE: rd_word[4:0] = tx_disable;
         `OFS_PMD_CONTROL: rd_word[`BIT_TRAIN_ENABLE] = train_enable;
         `OFS_SIGNAL_DETECT: rd_word[4:0] = {sd_stat, global_sd_stat};
         `OFS_FAULT: rd_word[2:0] = {tx_fault_q, rx_fault_q, rx_fault_q || tx_fault_q || (|resp_late)};
         `OFS_TRAIN_STATUS: rd_word[4*LANES-1:0] = train_q;
         `OFS_TEST_CONTROL: rd_word[1:0] = {fault_auto_dis, loopback};
         `OFS_RESP_LATE: rd_word[LANES-1:0] = resp_late;
         default: rd_word = 32'h00000000;
      endcase
   end

   // Read handshake, one outstanding read
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `AXI_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ==== bench/pmd_ctrl_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module pmd_ctrl_asserts
   import pmd_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] tx_bit,
   input wire pmd_mode_e tx_mode,
   input wire pmd_mode_e rx_mode,
   input wire logic [3:0] line_out,
   input wire logic [3:0] tx_enabled,
   input wire logic eq_use_preset,
   input wire logic global_signal_detect,
   input wire logic [3:0] lane_signal_detect,
   input wire logic [3:0] alert_energy,
   input wire logic train_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [4:0] energy_run;
   // Consecutive alert-level cycles on lane 0 while quiet; saturates so it never wraps
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         energy_run <= 5'h00;
      end else if (rx_mode == MODE_QUIET && train_enable && alert_energy[0]) begin
         energy_run <= (energy_run == 5'h1F) ? energy_run : energy_run + 5'h01;
      end else begin
         energy_run <= 5'h00;
      end
   end
   // Entry steps of the alert pattern and of quiet listening
   sequence s_alert_begin;
      (tx_mode != MODE_ALERT) ##1 (tx_mode == MODE_ALERT);
   endsequence
   sequence s_alert_run;
      (tx_mode == MODE_ALERT)[*8];
   endsequence
   sequence s_rx_quiet_entry;
      (rx_mode != MODE_QUIET) ##1 (rx_mode == MODE_QUIET && train_enable);
   endsequence
   a_line_follows: assert property ((tx_mode == MODE_DATA) ##1 (tx_enabled == 4'hF)
      |-> line_out == $past(tx_bit)) else $error("line level does not follow requested bit");
   a_alert_pattern: assert property (s_alert_begin ##1 s_alert_run
      |-> line_out == tx_enabled ##1 line_out == 4'h0) else $error("alert pattern phase wrong");
   a_preset_mode: assert property (1'b1 |=>
      eq_use_preset == ($past(tx_mode) == MODE_ALERT)) else $error("equalizer choice wrong");
   a_global_and: assert property (global_signal_detect == &lane_signal_detect)
      else $error("global detect is not the lane AND");
   a_train_off: assert property ((!train_enable)[*2] |-> lane_signal_detect == 4'hF)
      else $error("detect not forced with training off");
   a_quiet_clear: assert property (s_rx_quiet_entry |=> lane_signal_detect == 4'h0)
      else $error("detect not cleared on quiet entry");
   a_alert_detect: assert property (energy_run == 5'd12 |-> ##[0:2] lane_signal_detect[0])
      else $error("alert energy not detected in time");
   a_off_silent: assert property ((line_out & ~tx_enabled) == 4'h0)
      else $error("disabled lane is driving");
   a_quiet_off: assert property (tx_mode == MODE_QUIET |=> tx_enabled == 4'h0)
      else $error("transmitters on in quiet mode");
endmodule
bind quad_lane_pmd_control pmd_ctrl_asserts i_pmd_ctrl_asserts (
   .clk(clk), .sys_rst(sys_rst), .tx_bit(tx_bit), .tx_mode(tx_mode), .rx_mode(rx_mode),
   .line_out(line_out), .tx_enabled(tx_enabled), .eq_use_preset(eq_use_preset),
   .global_signal_detect(global_signal_detect), .lane_signal_detect(lane_signal_detect),
   .alert_energy(alert_energy), .train_enable(train_enable));
`default_nettype wire

// ==== bench/lp_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module lp_model
   import pmd_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic [3:0] data,
   input wire logic [3:0] alert,
   input wire logic [3:0] req,
   input wire logic [31:0] dly,
   output logic [3:0] line_in,
   output logic [3:0] alert_energy,
   output lane_frame_s [3:0] frame
);
   int cnt [4] = '{0, 0, 0, 0};
   // Frame state starts clean so the first update field is a defined value
   lane_frame_s [3:0] fr = '0;
   assign frame = fr;
   // Far transmitter and comparator reach our pins one clock late
   always @(posedge clk) begin
      line_in <= data;
      alert_energy <= alert;
   end
   // Delay 255 means the far side never answers
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         fr[i].rx_marker <= req[i];
         fr[i].tx_marker <= 1'b0;
         if (req[i]) begin
            fr[i].rx_coef_update <= fr[i].rx_coef_update + 6'h01;
            fr[i].tx_status_done <= 1'b0;
            cnt[i] <= int'(dly[8*i +: 8]);
         end else if (cnt[i] == 1) begin
            fr[i].tx_marker <= 1'b1;
            fr[i].tx_status_done <= 1'b1;
            cnt[i] <= 0;
         end else if (cnt[i] > 1 && cnt[i] < 255) begin
            cnt[i] <= cnt[i] - 1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pmd_ctrl_defs.svh"
module tb_top
   import pmd_ctrl_pkg::*;
();
   logic clk = 0, sys_rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, gsd, fault, eq_pre, tr_en, rst_tr;
   logic an_good = 0, rx_f = 0, tx_f = 0, mon = 0, gdis = 0, loop = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, dly = 0;
   logic [1:0] rresp, bresp;
   logic [3:0] tx_bit = 0, lp_data = 0, lp_alert = 0, train_sd = 0, req = 0, ldis = 0;
   logic [3:0] rx_bit, line_out, tx_en, line_in, energy, lsd, exp_line, exp_rx, exp_en;
   pmd_mode_e tx_mode = MODE_DATA, rx_mode = MODE_DATA;
   lane_train_s [3:0] train_st = '0;
   lane_frame_s [3:0] frame;
   int seed = 32'h1C8AB446, fails = 0, check_count = 0, ai = 0;
   quad_lane_pmd_control #(.RESP_LIMIT_CYC(20), .STARTUP_GRACE_CYC(10)) i_quad_lane_pmd_control (
      .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tx_bit(tx_bit), .rx_bit(rx_bit), .tx_mode(tx_mode), .rx_mode(rx_mode),
      .global_signal_detect(gsd), .lane_signal_detect(lsd), .pmd_fault(fault),
      .line_out(line_out), .tx_enabled(tx_en), .eq_use_preset(eq_pre), .line_in(line_in),
      .alert_energy(energy), .train_signal_detect(train_sd), .train_status(train_st),
      .train_frame(frame), .an_good_check_entry(an_good), .rx_fault_in(rx_f),
      .tx_fault_in(tx_f), .restart_training(rst_tr), .train_enable(tr_en));
   lp_model i_lp_model (.clk(clk), .data(lp_data), .alert(lp_alert), .req(req), .dly(dly),
      .line_in(line_in), .alert_energy(energy), .frame(frame));
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Reference model: judge last prediction, then predict from the settled inputs
   always @(negedge clk) begin
      if (mon) begin
         chk(line_out, exp_line);
         chk(rx_bit, exp_rx);
         chk(tx_en, exp_en);
      end
      exp_en = (gdis || tx_mode == MODE_QUIET) ? 4'h0 : ~ldis;
      exp_line = (tx_mode == MODE_ALERT) ? {4{ai < 8}} & exp_en : tx_bit & exp_en;
      ai = (tx_mode == MODE_ALERT) ? (ai + 1) % 16 : 0;
      exp_rx = loop ? tx_bit : line_in;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Both channels offered together; each released only once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      // Only the aligned words of the register map answer OKAY
      chk({30'h0, bresp}, {30'h0, (a <= `OFS_RESP_LATE && a[1:0] == 2'h0) ? `AXI_OKAY : `AXI_SLVERR});
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   // Random traffic both ways while the model watches every cycle
   task automatic run(input int n);
      @(posedge clk);
      mon = 1'b1;
      repeat (n) begin
         @(posedge clk);
         tx_bit <= 4'($random(seed));
         lp_data <= 4'($random(seed));
      end
      mon = 1'b0;
   endtask
   initial begin
      #200000;
      fails++;
      summarize;
   end
   initial begin
      wt(3);
      sys_rst <= 1'b0;
      axi_rd(`OFS_PMD_CONTROL, 32'h2, `AXI_OKAY);
      axi_wr(8'h40, 32'h1F);
      axi_rd(`OFS_TX_DISABLE, 32'h0, `AXI_OKAY);
      axi_rd(8'h40, 32'h0, `AXI_SLVERR);
      run(40);
      chk(eq_pre, 1'b0);
      axi_wr(`OFS_TX_DISABLE, 32'h4);
      ldis = 4'h2;
      run(20);
      axi_wr(`OFS_TEST_CONTROL, 32'h1);
      axi_wr(`OFS_TX_DISABLE, 32'h1);
      {gdis, ldis, loop} = 6'h21;
      run(20);
      axi_wr(`OFS_TX_DISABLE, 32'h0);
      gdis = 1'b0;
      run(20);
      axi_wr(`OFS_TEST_CONTROL, 32'h0);
      loop = 1'b0;
      tx_mode <= MODE_ALERT;
      run(40);
      chk(eq_pre, 1'b1);
      tx_mode <= MODE_QUIET;
      run(10);
      tx_mode <= MODE_DATA;
      run(10);
      train_sd <= 4'hF;
      wt(3);
      chk({gsd, lsd}, 5'h1F);
      train_sd <= 4'hB;
      wt(3);
      chk({gsd, lsd}, 5'h0B);
      axi_wr(`OFS_PMD_CONTROL, 32'h0);
      chk({tr_en, rst_tr}, 2'h0);
      wt(2);
      chk(lsd, 4'hF);
      axi_rd(`OFS_SIGNAL_DETECT, 32'h1F, `AXI_OKAY);
      axi_wr(`OFS_PMD_CONTROL, 32'h3);
      chk({tr_en, rst_tr}, 2'h3);
      train_sd <= 4'hF;
      rx_mode <= MODE_QUIET;
      wt(2);
      chk(lsd, 4'h0);
      chk(rst_tr, 1'b0);
      lp_alert <= 4'h5;
      wt(25);
      chk(lsd, 4'h5);
      rx_mode <= MODE_DATA;
      lp_alert <= 4'h0;
      rx_f <= 1'b1;
      wt(3);
      chk(fault, 1'b1);
      axi_rd(`OFS_FAULT, 32'h3, `AXI_OKAY);
      rx_f <= 1'b0;
      tx_f <= 1'b1;
      wt(3);
      tx_f <= 1'b0;
      axi_rd(`OFS_TX_DISABLE, 32'h1, `AXI_OKAY);
      axi_rd(`OFS_FAULT, 32'h0, `AXI_OKAY);
      axi_wr(`OFS_TEST_CONTROL, 32'h2);
      rx_f <= 1'b1;
      wt(3);
      rx_f <= 1'b0;
      axi_rd(`OFS_TX_DISABLE, 32'h1F, `AXI_OKAY);
      axi_wr(`OFS_TEST_CONTROL, 32'h0);
      axi_wr(`OFS_TX_DISABLE, 32'h0);
      train_st <= 16'($random(seed));
      wt(3);
      axi_rd(`OFS_TRAIN_STATUS, {16'h0, train_st}, `AXI_OKAY);
      dly <= 32'h001E03FF;
      req <= 4'h4;
      wt(1);
      req <= 4'h0;
      wt(40);
      axi_rd(`OFS_RESP_LATE, 32'h0, `AXI_OKAY);
      an_good <= 1'b1;
      wt(1);
      an_good <= 1'b0;
      wt(12);
      req <= 4'h3;
      wt(1);
      req <= 4'h0;
      wt(40);
      axi_rd(`OFS_RESP_LATE, 32'h1, `AXI_OKAY);
      chk(fault, 1'b1);
      summarize;
   end
endmodule
`default_nettype wire
